//--- hdl/cis_flag_bank.sv
// Purpose: Bank of sticky flags, set by hardware, cleared by strobes
// Assumes: Set and clear are one-cycle strobes in the clock domain
// Notes: A set in the same cycle as a clear leaves the flag set
`timescale 1ns/1ps
`default_nettype none

module cis_flag_bank #(
  parameter int unsigned WIDTH = 12
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clr_in,
  output logic [WIDTH-1:0] flags_out
);
  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;

  // Set beats clear so no event is lost during a clear
  assign flags_d = set_in | (flags_q & ~clr_in);
  assign flags_out = flags_q;

  // Flags start cleared
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      flags_q <= '0;
    else
      flags_q <= flags_d;
  end
endmodule

`default_nettype wire

//--- hdl/cis_irq_status.sv
// Purpose: Per-slot ceiling status, data-ready and FIFO level flags
// Assumes: Comparators, FIFO and data registers live outside this block
// Notes: Register reads answer one cycle after the read strobe
//
// How it works
// - Data update sets the slot's channel-one flag when over its ceiling.
// - Data update sets the slot's channel-two flag when over its ceiling.
// - Slot A..L map to status bits 0..11; bits 15..12 read zero.
// - Ceiling flags reset to zero; writing one clears, writing zero keeps.
// - With autoclear bit 15 set (reset default), FIFO read clears level flag.
// - Autoclear bits 0..11 default one; slot data read clears its ready flag.
// - FIFO level flag drives interrupt one only when enable bit 15 is set.
`timescale 1ns/1ps
`default_nettype none

module cis_irq_status
  (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [cis_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [cis_pkg::DATA_W-1:0] reg_wdata_in,
  output logic [cis_pkg::DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Data register update from the sequencer
  input wire logic data_update_in,
  input wire logic [cis_pkg::SLOT_W-1:0] update_slot_in,
  input wire logic ch1_over_ceiling_in,
  input wire logic ch2_over_ceiling_in,
  // FIFO and data register read events
  input wire logic fifo_level_event_in,
  input wire logic fifo_read_in,
  input wire logic [cis_pkg::NUM_SLOTS-1:0] slot_data_read_in,
  // Explicit write-one clears from the level and data status registers
  input wire logic fifo_level_clr_in,
  input wire logic [cis_pkg::NUM_SLOTS-1:0] data_ready_clr_in,
  // Flag views and interrupt
  output logic fifo_level_flag_out,
  output logic [cis_pkg::NUM_SLOTS-1:0] data_ready_flags_out,
  output logic irq_out1_out
);
  import cis_pkg::*;

  // One-hot slot decode; codes above slot L decode to nothing
  function automatic logic [NUM_SLOTS-1:0] slot_onehot(
    input logic [SLOT_W-1:0] idx,
    input logic en
  );
    logic [NUM_SLOTS-1:0] v;
    v = SLOTS_NONE;
    for (int i = 0; i < NUM_SLOTS; i++)
      if (en && (idx == SLOT_W'(i)))
        v[i] = 1'b1;
    return v;
  endfunction

  logic [DATA_W-1:0] aclr_q;
  logic [DATA_W-1:0] aclr_d;
  logic [DATA_W-1:0] irq_en_q;
  logic [DATA_W-1:0] irq_en_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic rvalid_q;
  logic [NUM_SLOTS-1:0] ch1_flags;
  logic [NUM_SLOTS-1:0] ch2_flags;
  logic [NUM_SLOTS-1:0] ready_flags;
  logic fifo_flag;

  // Address decode
  wire sel_ch1 = reg_addr_in == CHAN1_CEILING_STATUS_ADDR;
  wire sel_ch2 = reg_addr_in == CHAN2_CEILING_STATUS_ADDR;
  wire sel_aclr = reg_addr_in == INTERRUPT_AUTOCLEAR_ENABLES_ADDR;
  wire sel_irq_en = reg_addr_in == IRQ_OUT1_ENABLES_ADDR;

  // Ceiling flag set and clear terms
  wire [NUM_SLOTS-1:0] ch1_set =
    slot_onehot(update_slot_in, data_update_in && ch1_over_ceiling_in);
  wire [NUM_SLOTS-1:0] ch2_set =
    slot_onehot(update_slot_in, data_update_in && ch2_over_ceiling_in);
  wire [NUM_SLOTS-1:0] ch1_clr =
    (reg_wr_in && sel_ch1) ? reg_wdata_in[SLOT_MSB:0] : SLOTS_NONE;
  wire [NUM_SLOTS-1:0] ch2_clr =
    (reg_wr_in && sel_ch2) ? reg_wdata_in[SLOT_MSB:0] : SLOTS_NONE;

  // Data-ready flags: set on every update, autoclear gated per slot
  wire [NUM_SLOTS-1:0] ready_set = slot_onehot(update_slot_in, data_update_in);
  wire [NUM_SLOTS-1:0] ready_clr =
    (slot_data_read_in & aclr_q[SLOT_MSB:0]) | data_ready_clr_in;
  wire fifo_clr =
    (fifo_read_in && aclr_q[FIFO_BIT]) || fifo_level_clr_in;

  // Interrupt one: FIFO level and data-ready sources behind their enables
  wire irq_w = (fifo_flag && irq_en_q[FIFO_BIT]) ||
    (|(ready_flags & irq_en_q[SLOT_MSB:0]));

  // Control register write paths; reserved bits stay zero
  assign aclr_d = (reg_wr_in && sel_aclr) ? (reg_wdata_in & RW_MASK) : aclr_q;
  assign irq_en_d =
    (reg_wr_in && sel_irq_en) ? (reg_wdata_in & RW_MASK) : irq_en_q;

  // Read mux; unmapped offsets answer zero
  wire [DATA_W-1:0] rd_mux =
    sel_ch1 ? {4'h0, ch1_flags} :
    sel_ch2 ? {4'h0, ch2_flags} :
    sel_aclr ? aclr_q :
    sel_irq_en ? irq_en_q : READ_IDLE;
  assign rdata_d = reg_rd_in ? rd_mux : rdata_q;

  // One bank per source; inside each, a set beats a same-cycle clear
  cis_flag_bank #(.WIDTH(NUM_SLOTS)) u_ch1 (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .set_in(ch1_set),
    .clr_in(ch1_clr),
    .flags_out(ch1_flags)
  );

  cis_flag_bank #(.WIDTH(NUM_SLOTS)) u_ch2 (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .set_in(ch2_set),
    .clr_in(ch2_clr),
    .flags_out(ch2_flags)
  );

  cis_flag_bank #(.WIDTH(NUM_SLOTS)) u_ready (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .set_in(ready_set),
    .clr_in(ready_clr),
    .flags_out(ready_flags)
  );

  cis_flag_bank #(.WIDTH(1)) u_fifo (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .set_in(fifo_level_event_in),
    .clr_in(fifo_clr),
    .flags_out(fifo_flag)
  );

  // Control registers, read data and the registered interrupt
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      aclr_q <= AUTOCLEAR_RESET;
      irq_en_q <= IRQ_EN_RESET;
      rdata_q <= READ_IDLE;
      rvalid_q <= 1'b0;
      irq_out1_out <= 1'b0;
    end
    else
    begin
      aclr_q <= aclr_d;
      irq_en_q <= irq_en_d;
      rdata_q <= rdata_d;
      rvalid_q <= reg_rd_in;
      irq_out1_out <= irq_w;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign fifo_level_flag_out = fifo_flag;
  assign data_ready_flags_out = ready_flags;

  // Checks on the flag and interrupt behaviour
  property p_ch1_set;
    @(posedge clock_in) disable iff (sys_rst_in)
    (data_update_in && ch1_over_ceiling_in && update_slot_in <= SLOT_MSB)
    |=> ch1_flags[$past(update_slot_in)];
  endproperty
  a_ch1_set: assert property (p_ch1_set)
    else $error("channel one ceiling flag not set");

  property p_ch2_set;
    @(posedge clock_in) disable iff (sys_rst_in)
    (data_update_in && ch2_over_ceiling_in && update_slot_in <= SLOT_MSB)
    |=> ch2_flags[$past(update_slot_in)];
  endproperty
  a_ch2_set: assert property (p_ch2_set)
    else $error("channel two ceiling flag not set");

  property p_reserved_zero;
    @(posedge clock_in) disable iff (sys_rst_in)
    (reg_rd_in && (sel_ch1 || sel_ch2)) |=>
      reg_rdata_out[DATA_W-1:NUM_SLOTS] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bits read nonzero");

  property p_ch1_sticky;
    @(posedge clock_in) disable iff (sys_rst_in)
    1'b1 |=> ((~ch1_flags & $past(ch1_flags) & ~$past(ch1_clr)) == 12'h000);
  endproperty
  a_ch1_sticky: assert property (p_ch1_sticky)
    else $error("ceiling flag dropped without a write of one");

  property p_ch2_w1c;
    @(posedge clock_in) disable iff (sys_rst_in)
    (reg_wr_in && sel_ch2 && !data_update_in) |=>
      ((ch2_flags & $past(reg_wdata_in[SLOT_MSB:0])) == 12'h000);
  endproperty
  a_ch2_w1c: assert property (p_ch2_w1c)
    else $error("write of one did not clear ceiling flag");

  property p_fifo_autoclear;
    @(posedge clock_in) disable iff (sys_rst_in)
    (fifo_read_in && aclr_q[FIFO_BIT] && !fifo_level_event_in)
    |=> !fifo_level_flag_out;
  endproperty
  a_fifo_autoclear: assert property (p_fifo_autoclear)
    else $error("FIFO read did not clear level flag");

  property p_ready_autoclear;
    @(posedge clock_in) disable iff (sys_rst_in)
    1'b1 |=> ((ready_flags & $past(slot_data_read_in & aclr_q[SLOT_MSB:0]
      & ~ready_set)) == 12'h000);
  endproperty
  a_ready_autoclear: assert property (p_ready_autoclear)
    else $error("slot data read did not clear ready flag");

  property p_fifo_hold;
    @(posedge clock_in) disable iff (sys_rst_in)
    (fifo_flag && !aclr_q[FIFO_BIT] && !fifo_level_clr_in) |=> fifo_flag;
  endproperty
  a_fifo_hold: assert property (p_fifo_hold)
    else $error("level flag cleared with autoclear off");

  property p_irq_fifo;
    @(posedge clock_in) disable iff (sys_rst_in)
    (fifo_flag && irq_en_q[FIFO_BIT]) |=> irq_out1_out;
  endproperty
  a_irq_fifo: assert property (p_irq_fifo)
    else $error("enabled level flag did not drive interrupt");

  property p_irq_quiet;
    @(posedge clock_in) disable iff (sys_rst_in)
    (!irq_en_q[FIFO_BIT] && (ready_flags & irq_en_q[SLOT_MSB:0]) == 12'h000)
    |=> !irq_out1_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt driven with sources disabled");
endmodule

`default_nettype wire

//--- hdl/cis_pkg.sv
// Purpose: Shared constants for the ceiling status and autoclear block
// Assumes: 16-bit register words reached through the internal register port
// Notes: Offsets are word addresses as seen on that port
`default_nettype none

package cis_pkg;
  // Register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned NUM_SLOTS = 12;

  // Register offsets
  localparam logic [ADDR_W-1:0] CHAN1_CEILING_STATUS_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] CHAN2_CEILING_STATUS_ADDR = 8'h05;
  localparam logic [ADDR_W-1:0] INTERRUPT_AUTOCLEAR_ENABLES_ADDR = 8'h07;
  localparam logic [ADDR_W-1:0] IRQ_OUT1_ENABLES_ADDR = 8'h14;

  // Field positions
  localparam int unsigned FIFO_BIT = 15;
  localparam int unsigned SLOT_MSB = 11;

  // Reset values and writable masks
  localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] AUTOCLEAR_RESET = 16'h8fff;
  localparam logic [DATA_W-1:0] IRQ_EN_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] RW_MASK = 16'h8fff;
  localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;
  localparam logic [NUM_SLOTS-1:0] SLOTS_NONE = 12'h000;
endpackage

`default_nettype wire

//--- tb/cis_host_model.sv
// Purpose: Host side of the register port, issuing single-word accesses
// Assumes: Strobes change on the falling edge, one cycle wide
// Notes: Write data is inverted once released so stale data never lingers
`timescale 1ns/1ps
`default_nettype none

module cis_host_model
  import cis_pkg::*;
(
  input wire logic clock_in,
  input wire logic [cis_pkg::DATA_W-1:0] reg_rdata_in,
  input wire logic reg_rvalid_in,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [cis_pkg::ADDR_W-1:0] reg_addr_out,
  output logic [cis_pkg::DATA_W-1:0] reg_wdata_out
);
  // Idle bus at time zero
  initial
  begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 16'h0000;
  end

  // One write, held across exactly one rising edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clock_in);
    reg_wr_out = 1'b1;
    reg_addr_out = a;
    reg_wdata_out = d;
    @(negedge clock_in);
    reg_wr_out = 1'b0;
    reg_wdata_out = ~d;
  endtask

  // Answer lands one cycle after the strobe edge, taken mid-cycle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                    output logic v);
    @(negedge clock_in);
    reg_rd_out = 1'b1;
    reg_addr_out = a;
    @(negedge clock_in);
    reg_rd_out = 1'b0;
    d = reg_rdata_in;
    v = reg_rvalid_in;
  endtask
endmodule

`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench for ceiling status and autoclear flags
// Assumes: Inputs change on the falling edge of a 100 MHz clock
// Notes: Each scenario task drives and judges its own traffic
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import cis_pkg::*;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic wr, rd, rvalid, fflag, irq;
  logic upd = 1'b0;
  logic ch1 = 1'b0;
  logic ch2 = 1'b0;
  logic [3:0] slot = 4'h0;
  logic [2:0] fev = 3'h0;
  logic [11:0] srd = 12'h000;
  logic [11:0] sclr = 12'h000;
  logic [11:0] ready;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  cis_irq_status cis_irq_status_inst (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .data_update_in(upd), .update_slot_in(slot),
    .ch1_over_ceiling_in(ch1), .ch2_over_ceiling_in(ch2),
    .fifo_level_event_in(fev[0]), .fifo_read_in(fev[1]),
    .slot_data_read_in(srd), .fifo_level_clr_in(fev[2]),
    .data_ready_clr_in(sclr), .fifo_level_flag_out(fflag),
    .data_ready_flags_out(ready), .irq_out1_out(irq));
  cis_host_model cis_host_model_inst (.clock_in(clock_in),
    .reg_rdata_in(rdata), .reg_rvalid_in(rvalid), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_addr_out(addr), .reg_wdata_out(wdata));

  // Free-running clock
  initial
  begin
    forever #5 clock_in = ~clock_in;
  end

  // Hang guard, far above the hundred or so cycles needed
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      results();
    end
  end

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask

  task automatic rdchk(logic [7:0] a, logic [15:0] e);
    logic [15:0] d;
    logic v;
    cis_host_model_inst.rd(a, d, v);
    chk("rvalid", 16'h0001, {15'h0000, v});
    chk("rdata", e, d);
  endtask

  task automatic upd_p(logic [3:0] s, logic c1, logic c2);
    @(negedge clock_in);
    {upd, slot, ch1, ch2} = {1'b1, s, c1, c2};
    @(negedge clock_in);
    {upd, ch1, ch2} = 3'h0;
  endtask

  // Bit 0 level event, bit 1 fifo read, bit 2 explicit clear
  task automatic fpulse(logic [2:0] f);
    @(negedge clock_in);
    fev = f;
    @(negedge clock_in);
    fev = 3'h0;
  endtask

  task automatic spulse(logic [11:0] r, logic [11:0] c);
    @(negedge clock_in);
    {srd, sclr} = {r, c};
    @(negedge clock_in);
    {srd, sclr} = 24'h000000;
  endtask

  task automatic t_reset();
    rdchk(CHAN1_CEILING_STATUS_ADDR, 16'h0000);
    rdchk(CHAN2_CEILING_STATUS_ADDR, 16'h0000);
    rdchk(INTERRUPT_AUTOCLEAR_ENABLES_ADDR, 16'h8fff);
    rdchk(IRQ_OUT1_ENABLES_ADDR, 16'h0000);
    rdchk(8'h10, 16'h0000);
  endtask

  task automatic t_ceiling();
    upd_p(4'h0, 1'b1, 1'b0);
    upd_p(4'hb, 1'b0, 1'b1);
    upd_p(4'hc, 1'b1, 1'b1);
    rdchk(CHAN1_CEILING_STATUS_ADDR, 16'h0001);
    rdchk(CHAN2_CEILING_STATUS_ADDR, 16'h0800);
    cis_host_model_inst.wr(CHAN1_CEILING_STATUS_ADDR, 16'h0000);
    rdchk(CHAN1_CEILING_STATUS_ADDR, 16'h0001);
    cis_host_model_inst.wr(CHAN2_CEILING_STATUS_ADDR, 16'hffff);
    rdchk(CHAN2_CEILING_STATUS_ADDR, 16'h0000);
    cis_host_model_inst.wr(CHAN1_CEILING_STATUS_ADDR, 16'h0001);
    rdchk(CHAN1_CEILING_STATUS_ADDR, 16'h0000);
  endtask

  task automatic t_aclear();
    spulse(12'h000, 12'hfff);
    fpulse(3'h1);
    chk("fifo flag", 16'h0001, {15'h0000, fflag});
    fpulse(3'h2);
    chk("fifo flag", 16'h0000, {15'h0000, fflag});
    upd_p(4'h3, 1'b0, 1'b0);
    spulse(12'h008, 12'h000);
    chk("ready", 16'h0000, {4'h0, ready});
    cis_host_model_inst.wr(INTERRUPT_AUTOCLEAR_ENABLES_ADDR, 16'hffff);
    rdchk(INTERRUPT_AUTOCLEAR_ENABLES_ADDR, 16'h8fff);
    cis_host_model_inst.wr(INTERRUPT_AUTOCLEAR_ENABLES_ADDR, 16'h0000);
    fpulse(3'h1);
    fpulse(3'h2);
    upd_p(4'h3, 1'b0, 1'b0);
    spulse(12'h008, 12'h000);
    chk("fifo flag", 16'h0001, {15'h0000, fflag});
    chk("ready", 16'h0008, {4'h0, ready});
    fpulse(3'h4);
    spulse(12'h000, 12'h008);
    chk("fifo flag", 16'h0000, {15'h0000, fflag});
    chk("ready", 16'h0000, {4'h0, ready});
    fpulse(3'h5);
    chk("fifo flag", 16'h0001, {15'h0000, fflag});
  endtask

  // Reset in mid-run must restore flags and autoclear defaults
  task automatic t_rst_mid();
    upd_p(4'h5, 1'b1, 1'b1);
    @(negedge clock_in);
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clock_in);
    sys_rst_in = 1'b0;
    rdchk(CHAN1_CEILING_STATUS_ADDR, 16'h0000);
    rdchk(CHAN2_CEILING_STATUS_ADDR, 16'h0000);
    rdchk(INTERRUPT_AUTOCLEAR_ENABLES_ADDR, 16'h8fff);
    chk("fifo flag", 16'h0000, {15'h0000, fflag});
    chk("ready", 16'h0000, {4'h0, ready});
  endtask

  task automatic t_irq();
    fpulse(3'h1);
    @(negedge clock_in);
    chk("irq", 16'h0000, {15'h0000, irq});
    fpulse(3'h4);
    cis_host_model_inst.wr(IRQ_OUT1_ENABLES_ADDR, 16'h8000);
    rdchk(IRQ_OUT1_ENABLES_ADDR, 16'h8000);
    fpulse(3'h1);
    @(negedge clock_in);
    chk("irq", 16'h0001, {15'h0000, irq});
    fpulse(3'h4);
    cis_host_model_inst.wr(IRQ_OUT1_ENABLES_ADDR, 16'h0004);
    chk("irq", 16'h0000, {15'h0000, irq});
    upd_p(4'h2, 1'b0, 1'b0);
    @(negedge clock_in);
    chk("irq", 16'h0001, {15'h0000, irq});
  endtask

  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(negedge clock_in);
    sys_rst_in = 1'b0;
    t_reset();
    t_ceiling();
    t_aclear();
    t_rst_mid();
    t_irq();
    results();
  end
endmodule

`default_nettype wire
